// *** src/asw_pkg.sv ***
// constants shared by the slicer watchdog control block
`default_nettype none
package asw_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam logic [5:0] ADDR_COMPENSATION = 6'h0C;
   localparam logic [5:0] ADDR_SETTINGS = 6'h16;
   localparam logic [7:0] SETTINGS_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ---------------------------------------------------------------
   // settings field positions
   // ---------------------------------------------------------------
   localparam int BIT_ADAPTIVE_SLICER = 7;
   localparam int BIT_ADV_DETECTOR = 6;
   localparam int BIT_AUTOSCALE = 5;
   localparam int BIT_PUSHBACK = 4;
   localparam int BIT_WATCHDOG = 3;
   localparam int BIT_LIMIT_SEL = 2;
   localparam int STEP_SEL_HI = 1;
   localparam int STEP_SEL_LO = 0;

   // ---------------------------------------------------------------
   // watchdog arithmetic
   // ---------------------------------------------------------------
   localparam int SLICER_WATCHDOG_ENABLE_W = 13;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_ZERO = 13'h0000;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_SAT = 13'h1FFF;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_INC = 13'h0001;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_DEC = 13'h0008;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_MAX_LO = 13'h0400;
   localparam logic [12:0] SLICER_WATCHDOG_ENABLE_MAX_HI = 13'h0800;
   localparam logic [12:0] STEP_00 = 13'h0020;
   localparam logic [12:0] STEP_01 = 13'h0040;
   localparam logic [12:0] STEP_10 = 13'h0080;
   localparam logic [12:0] STEP_11 = 13'h0100;

   // ---------------------------------------------------------------
   // run length and slicer constants
   // ---------------------------------------------------------------
   localparam int RL_W = 4;
   localparam logic [3:0] RL_ONE = 4'h1;
   localparam logic [3:0] RL_TWO = 4'h2;
   localparam logic [3:0] RL_VALID_MIN = 4'h3;
   localparam logic [3:0] RL_VALID_MAX = 4'hB;
   localparam logic [3:0] RL_SAT = 4'hF;
   localparam logic [7:0] LEVEL_RESET = 8'h80;
   localparam logic [7:0] COMP_ZERO = 8'h00;
   localparam logic [7:0] COMP_POS_MAX = 8'h7F;
   localparam logic [7:0] COMP_NEG_MAX = 8'h80;
   localparam logic [7:0] LEVEL_ONE = 8'h01;
   localparam int DIV_W = 4;
   localparam logic [3:0] DIV_LAST = 4'hF;
   localparam int PB_DEPTH = 4;
endpackage
`default_nettype wire

// *** src/asw_sync2.sv ***
// two flip-flop synchroniser for pin inputs
`default_nettype none
module asw_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   // first stage is read only by the second stage
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_ff <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// *** src/asw_pushback.sv ***
// short run push-back: stretches two-long runs to three
`default_nettype none
module asw_pushback (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic tick,
   input wire logic enable,
   // sliced bit and its distance from the threshold
   input wire logic bit_in,
   input wire logic [7:0] margin_in,
   // delayed, corrected bit
   output logic bit_out
);
   logic [asw_pkg::PB_DEPTH-1:0] win_ff;
   logic [7:0] lead_margin_ff;
   logic [7:0] mid_margin_ff;
   logic short_run;
   logic fix_lead;
   logic fix_trail;

   // run of two sits in win_ff[1:0], bounded by win_ff[2] and bit_in
   assign short_run = enable && (win_ff[0] == win_ff[1]) && (win_ff[2] != win_ff[1]) && (bit_in != win_ff[0]);
   // the edge whose sample sat nearer the threshold is the suspect
   assign fix_lead = short_run && (lead_margin_ff <= margin_in); // see RULE_14
   assign fix_trail = short_run && !fix_lead; // see RULE_14

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         win_ff <= '0;
         lead_margin_ff <= asw_pkg::COMP_ZERO;
         mid_margin_ff <= asw_pkg::COMP_ZERO;
         bit_out <= 1'b0;
      end
      else if (tick)
      begin
         bit_out <= win_ff[3];
         win_ff[3] <= fix_lead ? win_ff[1] : win_ff[2];
         win_ff[2] <= win_ff[1];
         win_ff[1] <= win_ff[0];
         win_ff[0] <= fix_trail ? win_ff[0] : bit_in;
         lead_margin_ff <= mid_margin_ff;
         mid_margin_ff <= margin_in;
      end
   end
endmodule
`default_nettype wire

// *** src/asw_control.sv ***
// slicer, bit detector and slice-level watchdog control
`default_nettype none

// Behaviour
// RULE_01 - watchdog updates once per PLL clock
// RULE_02 - short run adds step, highest priority
// RULE_03 - no transition adds one
// RULE_04 - valid run transition subtracts eight
// RULE_05 - otherwise over maximum resets counter
// RULE_06 - counter reset also resets slice level
// RULE_07 - limit select picks 1024 or 2048
// RULE_08 - step select picks 32/64/128/256
// RULE_09 - settings bit 3 runs watchdog
// RULE_10 - bit 7 low holds slicer at zero
// RULE_11 - bit 6 enables advanced bit detector
// RULE_12 - bit 5 runs or holds auto-scaling
// RULE_13 - bit 4 enables short run push-back
// RULE_14 - push-back stretches run two to three
// RULE_15 - second slicer tracks faster than first
// RULE_16 - write-only settings register at 16H
// RULE_17 - read 0CH returns compensation value
// RULE_18 - disabled watchdog keeps counter at zero
module asw_control (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // front-end pins
   input wire logic pll_clk_pin,
   input wire logic [7:0] hf_sample_pin,
   // detected bit stream
   output logic detected_bit,
   output logic detected_bit_valid,
   // front-end controls
   output logic adaptive_slicer_enable,
   output logic advanced_bit_detector_enable,
   output logic frontend_autoscale_enable,
   output logic short_run_pushback_enable,
   // watchdog status
   output logic slicer_watchdog_fire
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [7:0] settings_ff;
   logic slicer_watchdog_enable;
   logic watchdog_limit_select;
   logic [1:0] watchdog_step_select;
   logic pll_sync;
   logic [7:0] sample_sync;
   logic pll_prev_ff;
   logic tick;
   logic [7:0] sample_ff;
   logic sample_valid_ff;
   logic [7:0] level_ff;
   logic [3:0] div_ff;
   logic [7:0] slicer_compensation_value;
   logic [7:0] comp_ff;
   logic [7:0] nxt_comp;
   logic signed [9:0] threshold;
   logic signed [9:0] sample_ext;
   logic signed [9:0] diff;
   logic [7:0] margin;
   logic first_bit;
   logic adaptive_bit;
   logic prev_bit_ff;
   logic transition;
   logic [3:0] rl_ff;
   logic short_run;
   logic valid_run;
   logic [12:0] slicer_watchdog_enable_ff;
   logic [12:0] nxt_slicer_watchdog_enable;
   logic [12:0] step_size;
   logic [12:0] slicer_watchdog_enable_max;
   logic slicer_watchdog_enable_reset;
   logic pb_bit;
   logic [7:0] reg_rdata_ff;

   // ---------------------------------------------------------------
   // settings register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         settings_ff <= asw_pkg::SETTINGS_RESET;
      end
      else if (reg_wr && (reg_addr == asw_pkg::ADDR_SETTINGS))
      begin
         settings_ff <= reg_wdata; // see RULE_16
      end
   end

   assign adaptive_slicer_enable = settings_ff[asw_pkg::BIT_ADAPTIVE_SLICER];
   assign advanced_bit_detector_enable = settings_ff[asw_pkg::BIT_ADV_DETECTOR]; // see RULE_11
   // autoscale low means the front-end holds its scale
   assign frontend_autoscale_enable = settings_ff[asw_pkg::BIT_AUTOSCALE]; // see RULE_12
   assign short_run_pushback_enable = settings_ff[asw_pkg::BIT_PUSHBACK]; // see RULE_13
   assign slicer_watchdog_enable = settings_ff[asw_pkg::BIT_WATCHDOG];
   assign watchdog_limit_select = settings_ff[asw_pkg::BIT_LIMIT_SEL];
   assign watchdog_step_select = settings_ff[asw_pkg::STEP_SEL_HI:asw_pkg::STEP_SEL_LO];

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // settings are write-only, so they read as zero like any hole
   always_ff @(posedge clk)
   begin
      if (!sys_rst && reg_rd && (reg_addr == asw_pkg::ADDR_COMPENSATION))
      begin
         reg_rdata_ff <= slicer_compensation_value; // see RULE_17
      end
      else
      begin
         reg_rdata_ff <= asw_pkg::READ_ZERO; // see RULE_16
      end
   end
   assign reg_rdata = reg_rdata_ff;
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   asw_sync2 #(
      .WIDTH(1)
   ) u_pll_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(pll_clk_pin),
      .sync_out(pll_sync)
   );

   // the sample bus settles long before the pll edge reaches tick
   asw_sync2 #(
      .WIDTH(8)
   ) u_sample_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(hf_sample_pin),
      .sync_out(sample_sync)
   );

   // ---------------------------------------------------------------
   // pll clock edge detect
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      pll_prev_ff <= !sys_rst && pll_sync;
   end
   // limitation: pll clock must stay below a quarter of clk
   assign tick = pll_sync && !pll_prev_ff; // see RULE_01

   // ---------------------------------------------------------------
   // sample capture
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sample_ff <= asw_pkg::LEVEL_RESET;
         sample_valid_ff <= 1'b0;
      end
      else
      begin
         sample_valid_ff <= tick;
         if (tick)
         begin
            sample_ff <= sample_sync;
         end
      end
   end

   // ---------------------------------------------------------------
   // first slicer: slow level tracking
   // ---------------------------------------------------------------
   assign first_bit = sample_ff >= level_ff;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         div_ff <= '0;
         level_ff <= asw_pkg::LEVEL_RESET;
      end
      else if (sample_valid_ff)
      begin
         div_ff <= div_ff + 4'h1;
         // one step per sixteen pll cycles keeps this loop narrow
         if (div_ff == asw_pkg::DIV_LAST)
         begin
            if (first_bit && (level_ff != 8'hFF))
            begin
               level_ff <= level_ff + asw_pkg::LEVEL_ONE;
            end
            else if (!first_bit && (level_ff != 8'h00))
            begin
               level_ff <= level_ff - asw_pkg::LEVEL_ONE;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // adaptive slicer: fast compensation on top of the first level
   // ---------------------------------------------------------------
   assign sample_ext = $signed({2'b00, sample_ff});
   assign threshold = $signed({2'b00, level_ff}) + $signed({{2{comp_ff[7]}}, comp_ff});
   assign diff = sample_ext - threshold;
   assign adaptive_bit = !diff[9];
   assign margin = diff[9] ? 8'(-diff) : 8'(diff);

   // compensation steps every pll cycle, sixteen times the first loop
   always_comb
   begin
      nxt_comp = comp_ff;
      if (adaptive_bit && (comp_ff != asw_pkg::COMP_POS_MAX))
      begin
         nxt_comp = comp_ff + asw_pkg::LEVEL_ONE; // see RULE_15
      end
      else if (!adaptive_bit && (comp_ff != asw_pkg::COMP_NEG_MAX))
      begin
         nxt_comp = comp_ff - asw_pkg::LEVEL_ONE; // see RULE_15
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         comp_ff <= asw_pkg::COMP_ZERO;
      end
      else if (!adaptive_slicer_enable || slicer_watchdog_enable_reset)
      begin
         comp_ff <= asw_pkg::COMP_ZERO; // see RULE_10 see RULE_06
      end
      else if (sample_valid_ff)
      begin
         comp_ff <= nxt_comp;
      end
   end

   assign slicer_compensation_value = comp_ff;

   // ---------------------------------------------------------------
   // run length measurement
   // ---------------------------------------------------------------
   assign transition = adaptive_bit != prev_bit_ff;
   assign short_run = transition && ((rl_ff == asw_pkg::RL_ONE) || (rl_ff == asw_pkg::RL_TWO));
   assign valid_run = transition && (rl_ff >= asw_pkg::RL_VALID_MIN) && (rl_ff <= asw_pkg::RL_VALID_MAX);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prev_bit_ff <= 1'b0;
         rl_ff <= asw_pkg::RL_ONE;
      end
      else if (sample_valid_ff)
      begin
         prev_bit_ff <= adaptive_bit;
         if (transition)
         begin
            rl_ff <= asw_pkg::RL_ONE;
         end
         else if (rl_ff != asw_pkg::RL_SAT)
         begin
            rl_ff <= rl_ff + asw_pkg::RL_ONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // watchdog counter
   // ---------------------------------------------------------------
   always_comb
   begin
      case (watchdog_step_select)
         2'b00: step_size = asw_pkg::STEP_00; // see RULE_08
         2'b01: step_size = asw_pkg::STEP_01; // see RULE_08
         2'b10: step_size = asw_pkg::STEP_10; // see RULE_08
         default: step_size = asw_pkg::STEP_11; // see RULE_08
      endcase
   end

   assign slicer_watchdog_enable_max = watchdog_limit_select ? asw_pkg::SLICER_WATCHDOG_ENABLE_MAX_HI : asw_pkg::SLICER_WATCHDOG_ENABLE_MAX_LO; // see RULE_07

   // overflow is judged only on a transition of an illegal length
   assign slicer_watchdog_enable_reset = slicer_watchdog_enable && sample_valid_ff && !short_run && transition && !valid_run
                       && (slicer_watchdog_enable_ff > slicer_watchdog_enable_max); // see RULE_05

   always_comb
   begin
      nxt_slicer_watchdog_enable = slicer_watchdog_enable_ff;
      if (short_run)
      begin
         // saturate rather than wrap, a wrap would hide a hang
         nxt_slicer_watchdog_enable = (slicer_watchdog_enable_ff > (asw_pkg::SLICER_WATCHDOG_ENABLE_SAT - step_size)) ? asw_pkg::SLICER_WATCHDOG_ENABLE_SAT : slicer_watchdog_enable_ff + step_size; // see RULE_02
      end
      else if (!transition)
      begin
         nxt_slicer_watchdog_enable = (slicer_watchdog_enable_ff == asw_pkg::SLICER_WATCHDOG_ENABLE_SAT) ? slicer_watchdog_enable_ff : slicer_watchdog_enable_ff + asw_pkg::SLICER_WATCHDOG_ENABLE_INC; // see RULE_03
      end
      else if (valid_run)
      begin
         nxt_slicer_watchdog_enable = (slicer_watchdog_enable_ff < asw_pkg::SLICER_WATCHDOG_ENABLE_DEC) ? asw_pkg::SLICER_WATCHDOG_ENABLE_ZERO : slicer_watchdog_enable_ff - asw_pkg::SLICER_WATCHDOG_ENABLE_DEC; // see RULE_04
      end
      else if (slicer_watchdog_enable_ff > slicer_watchdog_enable_max)
      begin
         nxt_slicer_watchdog_enable = asw_pkg::SLICER_WATCHDOG_ENABLE_ZERO; // see RULE_05
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         slicer_watchdog_enable_ff <= asw_pkg::SLICER_WATCHDOG_ENABLE_ZERO;
      end
      else if (!slicer_watchdog_enable)
      begin
         slicer_watchdog_enable_ff <= asw_pkg::SLICER_WATCHDOG_ENABLE_ZERO; // see RULE_09 see RULE_18
      end
      else if (sample_valid_ff)
      begin
         slicer_watchdog_enable_ff <= nxt_slicer_watchdog_enable; // see RULE_01
      end
   end

   always_ff @(posedge clk)
   begin
      slicer_watchdog_fire <= !sys_rst && slicer_watchdog_enable_reset; // see RULE_06
   end
   // ---------------------------------------------------------------
   // push-back and detector output
   // ---------------------------------------------------------------
   asw_pushback u_pushback (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(sample_valid_ff),
      .enable(short_run_pushback_enable),
      .bit_in(adaptive_bit),
      .margin_in(margin),
      .bit_out(pb_bit)
   );

   // with the advanced detector off the raw first slice is passed
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         detected_bit <= 1'b0;
         detected_bit_valid <= 1'b0;
      end
      else
      begin
         detected_bit_valid <= sample_valid_ff;
         if (sample_valid_ff)
         begin
            detected_bit <= advanced_bit_detector_enable ? pb_bit : first_bit; // see RULE_11
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/asw_control_sva.sv ***
// port checker for the slicer watchdog control block
`default_nettype none
module asw_control_sva (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // front end and status
   input wire logic pll_clk_pin,
   input wire logic detected_bit,
   input wire logic detected_bit_valid,
   input wire logic adaptive_slicer_enable,
   input wire logic advanced_bit_detector_enable,
   input wire logic frontend_autoscale_enable,
   input wire logic short_run_pushback_enable,
   input wire logic slicer_watchdog_fire
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // helper: cycles since the pll pin rose
   // ---------------------------------------------------------------
   logic pll_d_ff;
   logic [3:0] since_rise_ff;
   logic [3:0] nxt_since_rise;
   logic [3:0] en_w;
   assign en_w = {adaptive_slicer_enable, advanced_bit_detector_enable, frontend_autoscale_enable,
      short_run_pushback_enable};
   // saturates so a stopped pll never wraps back into range
   always_comb
   begin
      nxt_since_rise = (since_rise_ff == 4'hF) ? 4'hF : since_rise_ff + 4'h1;
      if (pll_clk_pin && !pll_d_ff)
      begin
         nxt_since_rise = 4'h0;
      end
   end
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pll_d_ff <= 1'b0;
         since_rise_ff <= 4'hF;
      end
      else
      begin
         pll_d_ff <= pll_clk_pin;
         since_rise_ff <= nxt_since_rise;
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence settings_wr_s;
      reg_wr && reg_addr == asw_pkg::ADDR_SETTINGS;
   endsequence
   sequence unmapped_rd_s;
      reg_rd && reg_addr != asw_pkg::ADDR_SETTINGS && reg_addr != asw_pkg::ADDR_COMPENSATION;
   endsequence
   property not_wr_p;
      !(reg_wr && reg_addr == asw_pkg::ADDR_SETTINGS) |=> $stable(en_w);
   endproperty
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   settings_wo_a: assert property (reg_rd && reg_addr == asw_pkg::ADDR_SETTINGS |=> reg_rdata == 8'h00)
      else $error("settings register readable");
   unmapped_zero_a: assert property (unmapped_rd_s |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   enable_load_a: assert property (settings_wr_s |=> en_w == $past(reg_wdata[7:4]))
      else $error("enables do not follow settings write");
   enable_hold_a: assert property (not_wr_p)
      else $error("enables changed without settings write");
   fire_pulse_a: assert property (slicer_watchdog_fire |=> !slicer_watchdog_fire [*3])
      else $error("watchdog fire longer than one cycle");
   fire_tick_a: assert property (slicer_watchdog_fire |-> since_rise_ff <= 4'hA)
      else $error("watchdog fire without pll edge");
   valid_pulse_a: assert property (detected_bit_valid |=> !detected_bit_valid [*3])
      else $error("bit valid pulse too long");
   valid_tick_a: assert property (detected_bit_valid |-> since_rise_ff <= 4'hA)
      else $error("bit valid without pll edge");
   bit_change_a: assert property ($changed(detected_bit) |-> detected_bit_valid)
      else $error("detected bit changed without valid");
endmodule
bind asw_control asw_control_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pll_clk_pin(pll_clk_pin), .detected_bit(detected_bit), .detected_bit_valid(detected_bit_valid),
   .adaptive_slicer_enable(adaptive_slicer_enable), .advanced_bit_detector_enable(advanced_bit_detector_enable),
   .frontend_autoscale_enable(frontend_autoscale_enable), .short_run_pushback_enable(short_run_pushback_enable),
   .slicer_watchdog_fire(slicer_watchdog_fire));
`default_nettype wire

// *** verif/asw_frontend_model.sv ***
// behavioural front end: recovered pll clock and hf samples
`default_nettype none
module asw_frontend_model (
   // clock
   input wire logic clk,
   // front-end pins
   output logic pll_clk_pin,
   output logic [7:0] hf_sample_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      pll_clk_pin = 1'b0;
      hf_sample_pin = 8'h00;
   end
   // one pll period is 8 clk; the pll stands low between frames
   task automatic send(input logic [7:0] s);
      @(posedge clk);
      hf_sample_pin <= s;
      repeat (2) @(posedge clk);
      pll_clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      pll_clk_pin <= 1'b0;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// *** verif/asw_control_tb_top.sv ***
// testbench for the slicer watchdog control block
`default_nettype none
module asw_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 20000;
   logic clk, sys_rst, reg_wr, reg_rd, pll_clk_pin, detected_bit, detected_bit_valid, fire;
   logic en_a, en_d, en_s, en_p;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, hf_sample_pin, v;
   int n_mismatch, cmp_count, cyc, fire_cnt;
   logic [7:0] pat [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hF0, 8'h00};
   asw_control dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_clk_pin(pll_clk_pin),
      .hf_sample_pin(hf_sample_pin), .detected_bit(detected_bit), .detected_bit_valid(detected_bit_valid),
      .adaptive_slicer_enable(en_a), .advanced_bit_detector_enable(en_d), .frontend_autoscale_enable(en_s),
      .short_run_pushback_enable(en_p), .slicer_watchdog_fire(fire));
   asw_frontend_model fe (.clk(clk), .pll_clk_pin(pll_clk_pin), .hf_sample_pin(hf_sample_pin));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (fire === 1'b1)
         fire_cnt++;
      if (cyc == LIMIT)
      begin
         n_mismatch++;
         $display("timeout after %0d cycles", cyc);
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // data stands only in the cycle after the read edge
   task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // count = n_short*step - 5*n_valid + 13 when the final long run ends
   task automatic wd_case(input logic [7:0] set, input int n_short, input int n_valid, input logic exp_fire);
      logic [7:0] lvl;
      reg_write(asw_pkg::ADDR_SETTINGS, set & 8'hF7);
      repeat (16) fe.send(8'h00);
      reg_write(asw_pkg::ADDR_SETTINGS, set);
      fire_cnt = 0;
      lvl = 8'h00;
      repeat (n_short + 1)
      begin
         lvl = ~lvl;
         fe.send(lvl);
      end
      repeat (n_valid)
      begin
         repeat (3) fe.send(lvl);
         lvl = ~lvl;
         fe.send(lvl);
      end
      repeat (13) fe.send(lvl);
      fe.send(~lvl);
      repeat (10) @(posedge clk);
      check("watchdog fire count", {7'h00, exp_fire}, fire_cnt[7:0]);
      if (exp_fire)
      begin
         reg_read(asw_pkg::ADDR_COMPENSATION, v);
         check("compensation after watchdog", 8'h00, v);
      end
   endtask
   // a lone run of two ones, counted at the detector output
   task automatic pb_case(input logic [7:0] set, input logic [7:0] exp_ones);
      logic [7:0] ones;
      ones = 8'h00;
      reg_write(asw_pkg::ADDR_SETTINGS, set);
      for (int i = 0; i < 16; i++)
      begin
         fe.send((i == 6 || i == 7) ? 8'hFF : 8'h00);
         #1 ones = ones + {7'h00, detected_bit};
      end
      check("detected ones", exp_ones, ones);
   endtask
   initial
   begin
      sys_rst = 1'b1;
      reg_addr = 6'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1 check("enables after reset", 8'h00, {4'h0, en_a, en_d, en_s, en_p});
      reg_read(asw_pkg::ADDR_COMPENSATION, v);
      check("compensation at reset", 8'h00, v);
      for (int i = 0; i < 6; i++)
      begin
         reg_write(asw_pkg::ADDR_SETTINGS, pat[i]);
         #1 check("enables", {4'h0, pat[i][7:4]}, {4'h0, en_a, en_d, en_s, en_p});
      end
      reg_write(asw_pkg::ADDR_SETTINGS, 8'hF0);
      reg_read(asw_pkg::ADDR_SETTINGS, v);
      check("settings read", 8'h00, v);
      reg_read(6'h3F, v);
      check("unmapped read", 8'h00, v);
      pb_case(8'h00, 8'h02);
      pb_case(8'h40, 8'h02);
      pb_case(8'h50, 8'h03);
      reg_write(asw_pkg::ADDR_SETTINGS, 8'h08);
      for (int i = 0; i < 20; i++)
         fe.send(i[0] ? 8'hFF : 8'h00);
      reg_read(asw_pkg::ADDR_COMPENSATION, v);
      check("compensation slicer off", 8'h00, v);
      wd_case(8'h88, 32, 0, 1'b1);
      wd_case(8'h88, 32, 3, 1'b0);
      wd_case(8'h88, 31, 0, 1'b0);
      wd_case(8'h89, 16, 0, 1'b1);
      wd_case(8'h8A, 8, 0, 1'b1);
      wd_case(8'h8A, 7, 0, 1'b0);
      wd_case(8'h8B, 4, 0, 1'b1);
      wd_case(8'h8F, 4, 0, 1'b0);
      wd_case(8'h8F, 8, 0, 1'b1);
      wd_case(8'h83, 8, 0, 1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
